// file: nsc_far_model.sv
// Purpose: Board straps and core request source facing nsc_top.
// Assumes: Tasks are called just after a rising clock edge.
// Notes: Idle address lines show the inverse of the last request.
`timescale 1ns/100ps
module nsc_far_model
  import nsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic route_valid_i,
  input wire nsc_route_s route_i,
  output logic func_o,
  output logic multi_o,
  output logic [1:0] chip_o,
  output logic [15:0] clk_sel_o,
  output logic [7:0] io_o,
  output logic req_valid_o,
  output logic [47:0] req_addr_o,
  output logic req_pci_o
);
  initial begin
    {func_o, multi_o, chip_o, clk_sel_o, io_o} = 28'h8000000;
    req_valid_o = 1'b0;
    req_addr_o = 48'h0;
    req_pci_o = 1'b0;
  end
  ////////////////////////////////////////
  task automatic set_straps(input logic [3:0] fm, input logic [15:0] s,
                            input logic [7:0] io);
    {func_o, multi_o, chip_o} <= fm;
    clk_sel_o <= s;
    io_o <= io & 8'h8F;
  endtask : set_straps

  // Address inverted after release so a stale value never matches
  task automatic send(input logic [47:0] a, input logic p,
                      output logic v, output nsc_route_s r);
    req_valid_o <= 1'b1;
    req_addr_o <= a;
    req_pci_o <= p;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_addr_o <= ~a;
    @(posedge clk_i);
    v = route_valid_i;
    r = route_i;
  endtask : send
endmodule : nsc_far_model

// file: nsc_pkg.sv
// Purpose: Constants and types for node strap configuration and decode.
// Assumes: 32-bit AHB-Lite register access, 48-bit request addresses.
// Notes: Strap sample delay covers the two-stage input synchroniser.
//
// Overview of operation
// RULE1: Functional mode when function/test strap is 1, test mode when 0.
// RULE2: Coherent multichip strap 1 selects multichip mode, 0 single chip.
// RULE3: In multichip mode chip number strap gives node; node owns [47:44].
// RULE4: 48-bit address, top four bits pick one of 16 nodes; code routes only nodes 0 to 3 and refuses the rest.
// RULE5: Clock select bit 15 high locks link clock, low allows software.
// RULE6: Clock select bit 14: 1 single-ended link reference, 0 differential.
// RULE7: Bits 13:12 pick link PHY clock 1.6, 3.2, 1.2 or 2.4 GHz.
// RULE8: Bits 11:10 divide PHY clock by 8, 4, 2, or use system clock.
// RULE9: Bits 13:10 all ones bypass PLL, link runs from 100 MHz reference.
// RULE10: Memory field 11111 direct reference, 01111 software programmed.
// RULE11: Else memory clock is ref*(bits8:5+30)/(bit9+3); board keeps ranges.
// RULE12: Core field 11111 direct reference, 011xx software, 01111 normal.
// RULE13: Core field 0110x async interface, 011x0 delayed debug control.
// RULE14: Otherwise core clock is ref*(bits3:0+30)/(bit4+1).
// RULE15: I/O strap bit 7 forces link cold start in 1.0 mode.
// RULE16: Board drives I/O strap bits 6 to 4 to zero.
// RULE17: I/O strap bit 0 enables SPI boot; low bits set PCI behaviour.
// RULE18: Link-port I/O is snooped coherently, PCI DMA is not.
// RULE19: Bit 43 clear goes to cache slices; 43:41 of 6, 7 go to links.
// RULE20: Directional port ranges without attached slave are refused.
// RULE21: Select value n picks address bits [2n+7:2n+6] as slice number.
// RULE22: Slice select defaults to bits 7:6 and is software writable.
// RULE23: Straps are sampled once after reset release and held.
package nsc_pkg;

  localparam int STRAP_W = 28;
  localparam logic [31:0] REG_SLICE_OFS = 32'h3FF00400;
  localparam logic [31:0] REG_STRAP_OFS = 32'h3FF00404;
  localparam logic [31:0] REG_LINK_OFS = 32'h3FF00408;
  localparam logic [31:0] REG_LCLK_OFS = 32'h3FF0040C;
  localparam logic [3:0] SLICE_SEL_RST = 4'h0;
  localparam logic [1:0] LINK_ATT_RST = 2'h3;
  localparam logic [1:0] CAP_WAIT = 2'h2;
  localparam logic [5:0] SLICE_BASE = 6'h06;
  localparam logic [3:0] NODE_COUNT = 4'h4;
  localparam logic [2:0] DIR_LINK0 = 3'h6;
  localparam logic [2:0] DIR_LINK1 = 3'h7;
  localparam int CS_LINK_HW = 15;
  localparam int CS_LINK_REF = 14;
  localparam int IO_FORCE_GEN1 = 7;
  localparam int IO_PCI_MASTER = 3;
  localparam int IO_EXT_ARB = 1;
  localparam int IO_SPI_BOOT = 0;
  localparam logic [3:0] LINK_BYPASS = 4'hF;
  localparam logic [4:0] FLD_DIRECT = 5'h1F;
  localparam logic [4:0] FLD_SOFT = 5'h0F;
  localparam logic [2:0] CORE_SOFT_TOP = 3'h3;
  localparam logic [3:0] CORE_ASYNC_PAT = 4'h6;
  localparam logic [3:0] CORE_DLY_PAT = 4'h6;
  localparam logic [5:0] MUL_OFS = 6'h1E;
  localparam logic [2:0] MEM_DIV_OFS = 3'h3;
  localparam logic [1:0] CORE_DIV_OFS = 2'h1;

  typedef enum logic [2:0] {
    TGT_SLICE, TGT_LINK0, TGT_LINK1, TGT_REMOTE, TGT_NONE
  } nsc_tgt_e;

  typedef enum logic [2:0] {
    LS_DIV8, LS_DIV4, LS_DIV2, LS_SYSTEM, LS_BYPASS
  } nsc_lsrc_e;

  typedef enum logic [1:0] {CM_PLL, CM_DIRECT, CM_SOFT} nsc_cmode_e;

  typedef struct packed {
    logic [7:0] io_cfg;
    logic [15:0] clk_sel;
    logic [1:0] chip;
    logic multi;
    logic func;
  } nsc_strap_s;

  localparam nsc_strap_s STRAP_RST = 28'h0000001;

  typedef struct packed {
    logic refuse;
    logic snoop;
    nsc_tgt_e tgt;
    logic [3:0] node;
    logic [1:0] slice;
  } nsc_route_s;

  typedef struct packed {
    logic done;
    logic func;
    logic multi;
    logic [1:0] node;
    logic link_sw_en;
    logic link_ref_single;
    logic [1:0] link_phy;
    nsc_lsrc_e link_src;
    logic link_gen1;
    nsc_cmode_e mem_mode;
    logic [5:0] mem_mul;
    logic [2:0] mem_div;
    nsc_cmode_e core_mode;
    logic [5:0] core_mul;
    logic [1:0] core_div;
    logic core_async;
    logic core_dly_dbg;
    logic core_debug;
    logic spi_boot;
    logic pci_master;
    logic pci_ext_arb;
  } nsc_clkcfg_s;

endpackage : nsc_pkg

// file: nsc_sync.sv
// Purpose: Two-flop synchroniser for a vector of slow pin levels.
// Assumes: Bits are independent static levels, no bus coherence needed.
// Notes: First stage feeds only the second stage.
`timescale 1ns/100ps
module nsc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : nsc_sync

// file: nsc_top.sv
// Purpose: Strap capture, clock configuration decode and node routing.
// Assumes: Straps are static while reset is released; AHB-Lite slave.
// Notes: Reads take one wait state, writes none; response always OKAY.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
module nsc_top
  import nsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic func_test_strap_i,
  input wire logic coherent_multichip_strap_i,
  input wire logic [1:0] chip_number_pins_i,
  input wire logic [15:0] clk_select_strap_i,
  input wire logic [7:0] io_config_strap_i,
  input wire logic req_valid_i,
  input wire logic [47:0] req_addr_i,
  input wire logic req_from_pci_i,
  output logic route_valid_o,
  output nsc_route_s route_o,
  output nsc_clkcfg_s clk_cfg_o
);

  ////////////////////////////////////////////////////////////////////////
  // Strap capture

  nsc_strap_s strap_raw;
  nsc_strap_s strap_sync;
  nsc_strap_s strap_q;
  logic [1:0] cap_cnt_q;
  logic cap_done_q;

  assign strap_raw = {io_config_strap_i, clk_select_strap_i,
                      chip_number_pins_i, coherent_multichip_strap_i,
                      func_test_strap_i};

  nsc_sync #(.W(STRAP_W)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(strap_raw),
    .q_o(strap_sync)
  );

  // Waits for the synchroniser to fill, then freezes until next reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
      strap_q <= STRAP_RST;
    end else if (!cap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == CAP_WAIT) begin
        strap_q <= strap_sync; // RULE23
        cap_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [3:0] slice_sel_q;
  logic [1:0] link_att_q;
  logic [3:0] lclk_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] addr_q;
  logic [31:0] hrdata_q;
  logic hready_q;

  wire bus_go = hsel_i && htrans_i[1] && hready_i;
  wire link_sw_en = !strap_q.clk_sel[CS_LINK_HW];
  wire wr_slice = wr_q && (addr_q == REG_SLICE_OFS);
  wire wr_link = wr_q && (addr_q == REG_LINK_OFS);
  wire wr_lclk = wr_q && (addr_q == REG_LCLK_OFS) && link_sw_en; // RULE5
  wire [31:0] rd_mux =
    (addr_q == REG_SLICE_OFS) ? {28'h0000000, slice_sel_q} :
    (addr_q == REG_STRAP_OFS) ? {4'h0, strap_q} :
    (addr_q == REG_LINK_OFS) ? {30'h0, link_att_q} :
    (addr_q == REG_LCLK_OFS) ? {28'h0000000, lclk_q} : 32'h00000000;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 32'h00000000;
    end else begin
      wr_q <= bus_go && hwrite_i;
      rd_q <= bus_go && !hwrite_i;
      if (bus_go) begin
        addr_q <= haddr_i;
      end
    end
  end

  // Read data one cycle late so a write just before it is visible
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_q <= 32'h00000000;
      hready_q <= 1'b1;
    end else begin
      hready_q <= !(bus_go && !hwrite_i);
      hrdata_q <= rd_q ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slice_sel_q <= SLICE_SEL_RST; // RULE22
      link_att_q <= LINK_ATT_RST;
      lclk_q <= 4'h0;
    end else begin
      if (wr_slice) begin
        slice_sel_q <= hwdata_i[3:0]; // RULE22
      end
      if (wr_link) begin
        link_att_q <= hwdata_i[1:0];
      end
      if (!cap_done_q && cap_cnt_q == CAP_WAIT) begin
        lclk_q <= strap_sync.clk_sel[13:10];
      end else if (wr_lclk) begin
        lclk_q <= hwdata_i[3:0];
      end
    end
  end

  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock and mode decode

  nsc_clkcfg_s cfg_d;
  wire [3:0] link_eff = link_sw_en ? lclk_q : strap_q.clk_sel[13:10]; // RULE5
  wire [4:0] mem_fld = strap_q.clk_sel[9:5];
  wire [4:0] core_fld = strap_q.clk_sel[4:0];
  wire core_soft = core_fld[4:2] == CORE_SOFT_TOP; // RULE12
  wire [7:0] io = strap_q.io_cfg;
  nsc_lsrc_e link_src;
  nsc_cmode_e mem_mode;
  nsc_cmode_e core_mode;

  assign link_src = (link_eff == LINK_BYPASS) ? LS_BYPASS : // RULE9
    (link_eff[1:0] == 2'h0) ? LS_DIV8 : // RULE8
    (link_eff[1:0] == 2'h1) ? LS_DIV4 :
    (link_eff[1:0] == 2'h2) ? LS_DIV2 : LS_SYSTEM;
  assign mem_mode = (mem_fld == FLD_DIRECT) ? CM_DIRECT : // RULE10
    (mem_fld == FLD_SOFT) ? CM_SOFT : CM_PLL;
  assign core_mode = (core_fld == FLD_DIRECT) ? CM_DIRECT : // RULE12
    core_soft ? CM_SOFT : CM_PLL;

  assign cfg_d = '{
    done: cap_done_q,
    func: strap_q.func, // RULE1
    multi: strap_q.multi, // RULE2
    node: strap_q.multi ? strap_q.chip : 2'h0, // RULE3
    link_sw_en: link_sw_en, // RULE5
    link_ref_single: strap_q.clk_sel[CS_LINK_REF], // RULE6
    link_phy: link_eff[3:2], // RULE7
    link_src: link_src,
    link_gen1: io[IO_FORCE_GEN1], // RULE15
    mem_mode: mem_mode,
    mem_mul: {2'h0, mem_fld[3:0]} + MUL_OFS, // RULE11
    mem_div: {2'h0, mem_fld[4]} + MEM_DIV_OFS, // RULE11
    core_mode: core_mode,
    core_mul: {2'h0, core_fld[3:0]} + MUL_OFS, // RULE14
    core_div: {1'b0, core_fld[4]} + CORE_DIV_OFS, // RULE14
    core_async: core_fld[4:1] == CORE_ASYNC_PAT, // RULE13
    core_dly_dbg: {core_fld[4:2], core_fld[0]} == CORE_DLY_PAT, // RULE13
    core_debug: core_soft && (core_fld != FLD_SOFT), // RULE12
    spi_boot: io[IO_SPI_BOOT], // RULE17
    pci_master: io[IO_PCI_MASTER], // RULE17
    pci_ext_arb: io[IO_EXT_ARB] // RULE17
  };

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_cfg_o <= '0;
    end else begin
      clk_cfg_o <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request routing

  nsc_tgt_e tgt;
  nsc_route_s route_d;
  wire [3:0] req_node = req_addr_i[47:44]; // RULE4
  wire [3:0] local_node = {2'h0, cfg_d.node};
  wire req_local = req_node == local_node; // RULE3
  wire [2:0] req_dir = req_addr_i[43:41];
  wire remote_ok = strap_q.multi && (req_node < NODE_COUNT);
  wire [5:0] slice_lo = {1'b0, slice_sel_q, 1'b0} + SLICE_BASE;
  wire [1:0] req_slice = req_addr_i[slice_lo +: 2]; // RULE21

  // Unattached ports and the unused directional slots are refused
  assign tgt = !req_local ? (remote_ok ? TGT_REMOTE : TGT_NONE) :
    !req_addr_i[43] ? TGT_SLICE : // RULE19
    (req_dir == DIR_LINK0 && link_att_q[0]) ? TGT_LINK0 : // RULE19
    (req_dir == DIR_LINK1 && link_att_q[1]) ? TGT_LINK1 : // RULE19
    TGT_NONE; // RULE20

  assign route_d = '{
    refuse: tgt == TGT_NONE, // RULE20
    snoop: !req_from_pci_i, // RULE18
    tgt: tgt,
    node: req_node,
    slice: (tgt == TGT_SLICE) ? req_slice : 2'h0
  };

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_valid_o <= 1'b0;
      route_o <= '0;
    end else begin
      route_valid_o <= req_valid_i;
      if (req_valid_i) begin
        route_o <= route_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_strap_hold_frozen: assert property ( // RULE23
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q |=> $stable(strap_q) && cap_done_q)
    else $error("straps changed after capture");

  a_node_local_owned: assert property ( // RULE3
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_local && !req_addr_i[43]
    |=> route_valid_o && route_o.tgt == TGT_SLICE)
    else $error("local cache address not routed to slice");

  a_link0_dir_route: assert property ( // RULE19
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_local && req_dir == DIR_LINK0 && link_att_q[0]
    |=> route_o.tgt == TGT_LINK0 && !route_o.refuse)
    else $error("link 0 range misrouted");

  a_reserved_port_refuse: assert property ( // RULE20
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_local && req_addr_i[43] && req_dir[2:1] != 2'h3
    |=> route_o.refuse)
    else $error("reserved directional range accepted");

  a_slice_bit_pick: assert property ( // RULE21
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && tgt == TGT_SLICE |=> route_o.slice == $past(req_slice))
    else $error("wrong slice bits selected");

  a_pci_no_snoop: assert property ( // RULE18
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i |=> route_o.snoop != $past(req_from_pci_i))
    else $error("snoop flag wrong for source");

  a_link_bypass_sel: assert property ( // RULE9
    @(posedge clk_i) disable iff (!rst_n_i)
    link_eff == LINK_BYPASS |=> clk_cfg_o.link_src == LS_BYPASS)
    else $error("link bypass not selected");

  a_mem_mul_value: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rst_n_i)
    mem_mode == CM_PLL
    |=> clk_cfg_o.mem_mul == {2'h0, $past(mem_fld[3:0])} + 6'h1E)
    else $error("memory multiplier wrong");

  a_lclk_locked_hw: assert property ( // RULE5
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q && !link_sw_en |=> $stable(lclk_q))
    else $error("link clock written while strap-locked");

  a_func_mode_pass: assert property ( // RULE1
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q |=> clk_cfg_o.func == $past(strap_q.func))
    else $error("functional mode strap not passed on");

  a_single_chip_node: assert property ( // RULE2
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q && !strap_q.multi |=> clk_cfg_o.node == 2'h0)
    else $error("single chip mode reports a nonzero node");

  a_remote_node_route: assert property ( // RULE4
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && !req_local && remote_ok
    |=> route_o.tgt == TGT_REMOTE && route_o.node == $past(req_node))
    else $error("remote node request misrouted");

  a_link_sw_follow: assert property ( // RULE5
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q
    |=> clk_cfg_o.link_sw_en != $past(strap_q.clk_sel[CS_LINK_HW]))
    else $error("link software enable wrong");

  a_link_ref_pick: assert property ( // RULE6
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q
    |=> clk_cfg_o.link_ref_single == $past(strap_q.clk_sel[CS_LINK_REF]))
    else $error("link reference input wrong");

  a_link_div8_sel: assert property ( // RULE8
    @(posedge clk_i) disable iff (!rst_n_i)
    link_eff != LINK_BYPASS && link_eff[1:0] == 2'h0
    |=> clk_cfg_o.link_src == LS_DIV8)
    else $error("link divide by 8 not selected");

  a_mem_direct_sel: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rst_n_i)
    mem_fld == FLD_DIRECT |=> clk_cfg_o.mem_mode == CM_DIRECT)
    else $error("memory direct clock not selected");

  a_core_soft_sel: assert property ( // RULE12
    @(posedge clk_i) disable iff (!rst_n_i)
    core_fld[4:2] == CORE_SOFT_TOP |=> clk_cfg_o.core_mode == CM_SOFT)
    else $error("core software clock not selected");

  a_core_async_mode: assert property ( // RULE13
    @(posedge clk_i) disable iff (!rst_n_i)
    core_fld[4:1] == CORE_ASYNC_PAT |=> clk_cfg_o.core_async)
    else $error("core asynchronous interface not flagged");

  a_core_div_value: assert property ( // RULE14
    @(posedge clk_i) disable iff (!rst_n_i)
    core_mode == CM_PLL
    |=> clk_cfg_o.core_div == {1'b0, $past(core_fld[4])} + 2'h1)
    else $error("core divider wrong");

  a_gen1_force_pick: assert property ( // RULE15
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_done_q |=> clk_cfg_o.link_gen1 == $past(io[IO_FORCE_GEN1]))
    else $error("link cold start mode wrong");

endmodule : nsc_top

// file: test_node_strap_config_and_address_decode.sv
// Purpose: Self-checking bench for strap capture, clock decode, routing.
// Assumes: One wait state on reads; config valid four edges after reset.
// Notes: Straps are inverted after capture to prove they are held.
`timescale 1ns/100ps
module test_node_strap_config_and_address_decode
  import nsc_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, hready, hresp, rv;
  logic func, multi, req_valid, req_pci;
  logic [1:0] htrans, chip;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [47:0] req_addr;
  logic [15:0] cs;
  logic [7:0] io;
  nsc_route_s route;
  nsc_clkcfg_s cfg, e;
  int errors, checks;
  localparam logic [15:0] CS_T [5] = '{16'hFFFF, 16'h01EF, 16'h566C,
                                       16'h2CB2, 16'h8C00};
  localparam logic [7:0] IO_T [5] = '{8'hF1, 8'h0A, 8'h00, 8'h09, 8'h02};
  localparam logic [3:0] FM_T [5] = '{4'hE, 4'h3, 4'hD, 4'hF, 4'h8};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  nsc_top i_dut (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .func_test_strap_i(func), .coherent_multichip_strap_i(multi),
    .chip_number_pins_i(chip), .clk_select_strap_i(cs),
    .io_config_strap_i(io), .req_valid_i(req_valid),
    .req_addr_i(req_addr), .req_from_pci_i(req_pci),
    .route_valid_o(rv), .route_o(route), .clk_cfg_o(cfg));

  nsc_far_model i_far (.clk_i(clk), .route_valid_i(rv), .route_i(route),
    .func_o(func), .multi_o(multi), .chip_o(chip), .clk_sel_o(cs),
    .io_o(io), .req_valid_o(req_valid), .req_addr_o(req_addr),
    .req_pci_o(req_pci));
  ////////////////////////////////////////
  task automatic end_sim;
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic hwait;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (i > 20) begin
        errors++;
        end_sim;
      end
    end while (hready !== 1'b1);
  endtask : hwait

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hwait;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    hwait;
    rd = hrdata;
    chk(64'(hresp), 64'h0);
  endtask : ahb

  task automatic rt(input logic [47:0] a, input logic p,
                    input nsc_tgt_e t, input logic [1:0] s);
    logic v;
    nsc_route_s r;
    i_far.send(a, p, v, r);
    chk(64'(v), 64'h1);
    chk(64'(r.node), 64'(a[47:44]));
    chk(64'({r.refuse, r.snoop, r.tgt, r.tgt === TGT_SLICE ? r.slice : 2'h0}),
        64'({t == TGT_NONE, !p, t, s}));
  endtask : rt

  function automatic nsc_clkcfg_s exp_cfg(input logic [15:0] c,
      input logic [7:0] o, input logic [3:0] fm);
    nsc_clkcfg_s r;
    r = '0;
    {r.done, r.func, r.multi} = {1'b1, fm[3:2]};
    // Chip pins only name the node in multichip mode
    r.node = fm[2] ? fm[1:0] : 2'h0;
    {r.link_sw_en, r.link_ref_single, r.link_phy} = {!c[15], c[14:12]};
    r.link_src = c[13:10] == 4'hF ? LS_BYPASS : nsc_lsrc_e'({1'b0, c[11:10]});
    r.link_gen1 = o[7];
    r.mem_mode = c[9:5] == 5'h1F ? CM_DIRECT :
                 c[9:5] == 5'h0F ? CM_SOFT : CM_PLL;
    r.mem_mul = {2'h0, c[8:5]} + 6'h1E;
    r.mem_div = {2'h0, c[9]} + 3'h3;
    r.core_mode = c[4:0] == 5'h1F ? CM_DIRECT :
                  c[4:2] == 3'h3 ? CM_SOFT : CM_PLL;
    r.core_mul = {2'h0, c[3:0]} + 6'h1E;
    r.core_div = {1'b0, c[4]} + 2'h1;
    r.core_async = c[4:1] == 4'h6;
    r.core_dly_dbg = {c[4:2], c[0]} == 4'h6;
    r.core_debug = c[4:2] == 3'h3 && c[4:0] != 5'h0F;
    {r.spi_boot, r.pci_master, r.pci_ext_arb} = {o[0], o[3], o[1]};
    return r;
  endfunction : exp_cfg
  ////////////////////////////////////////
  initial begin
    int k;
    int n;
    logic [15:0] c2;
    logic [7:0] iom;
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    errors = 0;
    checks = 0;
    for (k = 0; k < 5; k++) begin
      rst_n <= 1'b0;
      i_far.set_straps(FM_T[k], CS_T[k], IO_T[k]);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      iom = IO_T[k] & 8'h8F;
      e = exp_cfg(CS_T[k], iom, FM_T[k]);
      chk(64'(cfg), 64'(e));
      chk(64'(cfg[26:16]), 64'(e[26:16]));
      chk(64'(cfg[15:3]), 64'(e[15:3]));
      chk(64'({cfg[27], cfg[2:0]}), 64'({e[27], e[2:0]}));
      ahb(1'b0, REG_STRAP_OFS, 32'h0, d);
      chk(64'(d),
          64'({iom, CS_T[k], FM_T[k][1:0], FM_T[k][2], FM_T[k][3]}));
      ahb(1'b0, REG_SLICE_OFS, 32'h0, d);
      chk(64'(d), 64'h0);
      ahb(1'b0, REG_LCLK_OFS, 32'h0, d);
      chk(64'(d), 64'(CS_T[k][13:10]));
      // Later pin changes must not reach the decoded config
      i_far.set_straps(~FM_T[k], ~CS_T[k], ~IO_T[k]);
      repeat (4) @(posedge clk);
      chk(64'(cfg), 64'(e));
      ahb(1'b1, REG_LCLK_OFS, 32'h7, d);
      ahb(1'b0, REG_LCLK_OFS, 32'h0, d);
      c2 = CS_T[k];
      if (!c2[15]) begin
        c2[13:10] = 4'h7;
      end
      chk(64'(d), 64'(c2[13:10]));
      repeat (2) @(posedge clk);
      chk(64'(cfg), 64'(exp_cfg(c2, iom, FM_T[k])));
      if (k == 0) begin
        ahb(1'b0, REG_LINK_OFS, 32'h0, d);
        chk(64'(d), 64'h3);
        ahb(1'b1, 32'h3FF00410, 32'hF, d);
        ahb(1'b0, 32'h3FF00410, 32'h0, d);
        chk(64'(d), 64'h0);
        for (n = 0; n < 16; n++) begin
          ahb(1'b1, REG_SLICE_OFS, 32'(n), d);
          ahb(1'b0, REG_SLICE_OFS, 32'h0, d);
          chk(64'(d), 64'(n));
          rt(48'h2000_0000_0000 | (48'(n % 4) << (2 * n + 6)), n[0],
             TGT_SLICE, 2'(n % 4));
        end
        rt(48'h2C00_0000_0000, 1'b0, TGT_LINK0, 2'h0);
        rt(48'h2E00_0000_0000, 1'b1, TGT_LINK1, 2'h0);
        rt(48'h2800_0000_0000, 1'b0, TGT_NONE, 2'h0);
        rt(48'h1000_0000_0000, 1'b0, TGT_REMOTE, 2'h0);
        rt(48'h5000_0000_0000, 1'b0, TGT_NONE, 2'h0);
        ahb(1'b1, REG_LINK_OFS, 32'h0, d);
        rt(48'h2C00_0000_0000, 1'b0, TGT_NONE, 2'h0);
        rt(48'h2E00_0000_0000, 1'b0, TGT_NONE, 2'h0);
      end
      if (k == 1) begin
        rt(48'h0000_0000_0040, 1'b1, TGT_SLICE, 2'h1);
        rt(48'h3000_0000_0000, 1'b0, TGT_NONE, 2'h0);
      end
    end
    end_sim;
  end
endmodule : test_node_strap_config_and_address_decode
